// ---- rtl/lcdt_params.svh ----
// constants for the lcd multiplex drive timing block
`ifndef LCDT_PARAMS_SVH
`define LCDT_PARAMS_SVH

// system clock and internal oscillator
`define LCDT_MCLK_HZ          50000000
`define LCDT_OSC_HZ           200000
`define LCDT_OSC_HALF_CYC     (`LCDT_MCLK_HZ / (2 * `LCDT_OSC_HZ))

// working clock periods per frame
`define LCDT_DIV_NORMAL       12'd2880
`define LCDT_DIV_PSAVE        12'd480

// register byte addresses
`define LCDT_ADR_CTRL         8'h00
`define LCDT_ADR_STATUS       8'h04
`define LCDT_ADR_PLANE0       8'h10
`define LCDT_ADR_PLANE3       8'h1c

// control fields
`define LCDT_CTRL_MODE_LSB    0
`define LCDT_CTRL_HALF_BIT    2
`define LCDT_CTRL_PSAVE_BIT   3
`define LCDT_CTRL_EN_BIT      4
`define LCDT_CTRL_RESET       5'h03

// drive level codes
`define LCDT_LVL_VDD          2'h0
`define LCDT_LVL_LOW_MID      2'h1
`define LCDT_LVL_HIGH_MID     2'h2
`define LCDT_LVL_VLCD         2'h3

`define LCDT_NUM_SEG          24

`endif

// ---- rtl/lcdt_pkg.sv ----
// types for the lcd multiplex drive timing block
`default_nettype none
package lcdt_pkg;
   typedef enum logic [1:0] {
      LCDT_STATIC = 2'b00,
      LCDT_MUX2   = 2'b01,
      LCDT_MUX3   = 2'b10,
      LCDT_MUX4   = 2'b11
   } lcdt_mode_type;
endpackage
`default_nettype wire

// ---- rtl/lcdt_drive.sv ----
// lcd multiplex drive timing: clock source, frame divider, display register, drivers
//
// Contract
// - one working clock times all drive logic
// - select low: internal oscillator drives clock pin
// - select high: clock pin is external input
// - normal mode frame is 2880 clocks
// - power-saving frame is 480 clocks
// - frame rate follows divider and clock source
// - hold serial clock low until byte stored
// - display register maps bits to segments
// - shift register preloads next plane meanwhile
// - 24 segments from phase and data
// - four backplanes, mode dependent, distinct in 1:4
// - 1:3 backplane 3 copies backplane 1
// - 1:2 pairs backplanes 2/0 and 3/1
// - static drives all backplanes alike
// - level count from mode and bias
// - half bias allowed in 1:2, 1:3, 1:4
// - cascade sync aligns multiplex timing
// - reset: 1:4, third bias, outputs at supply
// - bit planes shown in order per mode
//
// The Wishbone slave port and the placing of the registers were decided locally.
`include "lcdt_params.svh"
`default_nettype none
module lcdt_drive
   import lcdt_pkg::*;
(
   // clock and reset
   input  wire logic                         mclk_i,
   input  wire logic                         reset_n_i,
   // wishbone slave
   input  wire logic                         wb_cyc_i,
   input  wire logic                         wb_stb_i,
   input  wire logic                         wb_we_i,
   input  wire logic [7:0]                   wb_adr_i,
   input  wire logic [3:0]                   wb_sel_i,
   input  wire logic [31:0]                  wb_dat_i,
   output logic      [31:0]                  wb_dat_o,
   output logic                              wb_ack_o,
   // clock source
   input  wire logic                         oscillator_select_i,
   input  wire logic                         clk_pin_i,
   output logic                              clk_pin_o,
   output logic                              clk_pin_oe_o,
   // cascade synchronisation, open drain
   input  wire logic                         cascade_sync_i,
   output logic                              cascade_sync_o,
   output logic                              cascade_sync_oe_o,
   // display data bytes from the command side, serial clock stretch
   input  wire logic                         byte_valid_i,
   input  wire logic [7:0]                   byte_data_i,
   output logic                              byte_stored_o,
   output logic      [7:0]                   byte_stored_data_o,
   output logic                              scl_o,
   output logic                              scl_oe_o,
   // lcd drive, 2-bit level codes, level count, frame rate
   output logic      [1:0]                   backplane_0_o,
   output logic      [1:0]                   backplane_1_o,
   output logic      [1:0]                   backplane_2_o,
   output logic      [1:0]                   backplane_3_o,
   output logic      [2*`LCDT_NUM_SEG-1:0]   segment_outputs_o,
   output logic      [2:0]                   bias_levels_o,
   output logic                              frame_rate_o
);

   // active planes per mode
   function automatic logic [2:0] lcdt_planes(input lcdt_mode_type m);
      lcdt_planes = {1'b0, m} + 3'd1;
   endfunction

   // working clocks per slot: half a frame split over the active planes
   function automatic logic [11:0] lcdt_slot_len(input lcdt_mode_type m, input logic ps);
      logic [11:0] div;
      div = ps ? `LCDT_DIV_PSAVE : `LCDT_DIV_NORMAL;
      unique case (m)
         LCDT_STATIC: lcdt_slot_len = div >> 1;
         LCDT_MUX2:   lcdt_slot_len = div >> 2;
         LCDT_MUX3:   lcdt_slot_len = 12'(div / 12'd6);
         LCDT_MUX4:   lcdt_slot_len = div >> 3;
      endcase
   endfunction

   // phase carried by each backplane pin
   function automatic logic [1:0] lcdt_bp_phase(input lcdt_mode_type m, input logic [1:0] bp);
      unique case (m)
         LCDT_STATIC: lcdt_bp_phase = 2'h0;
         LCDT_MUX2:   lcdt_bp_phase = {1'b0, bp[0]};
         LCDT_MUX3:   lcdt_bp_phase = (bp == 2'h3) ? 2'h1 : bp;
         LCDT_MUX4:   lcdt_bp_phase = bp;
      endcase
   endfunction

   // backplane level: active extreme, otherwise the inner level of the bias
   function automatic logic [1:0] lcdt_bp_level(input logic act, input logic pol,
                                                 input logic half);
      if (act) begin
         lcdt_bp_level = pol ? `LCDT_LVL_VLCD : `LCDT_LVL_VDD;
      end else if (half) begin
         lcdt_bp_level = `LCDT_LVL_LOW_MID;
      end else begin
         lcdt_bp_level = pol ? `LCDT_LVL_LOW_MID : `LCDT_LVL_HIGH_MID;
      end
   endfunction

   // control register
   lcdt_mode_type mode_r;
   logic          half_r;
   logic          psave_r;
   logic          enable_r;

   // display memory: one 24-bit word per bit plane
   logic [`LCDT_NUM_SEG-1:0] plane_mem [4];

   // clock source
   logic [15:0] osc_cnt_r;
   logic        osc_lvl_r;
   logic        ext_prev_r;
   logic        tick;

   // frame timing
   logic [11:0] slot_cnt_r;
   logic [1:0]  phase_r;
   logic        pol_r;
   logic        slot_end;
   logic [1:0]  next_phase;
   logic        sync_seen;

   // data path
   logic [`LCDT_NUM_SEG-1:0] shift_r;
   logic [`LCDT_NUM_SEG-1:0] disp_r;
   logic [4:0]               shift_cnt_r;

   // byte stretch buffers
   logic       buf_a_vld_r;
   logic       buf_b_vld_r;
   logic [7:0] buf_a_r;
   logic [7:0] buf_b_r;

   logic [2:0] planes;
   logic       bus_req;
   logic       wr_ctrl;

   assign planes  = lcdt_planes(mode_r);
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_ctrl = bus_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `LCDT_ADR_CTRL);

   // wishbone: one wait state, ack drops in the following cycle
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         wb_dat_o <= 32'h0000_0000;
         if (bus_req && !wb_we_i) begin
            if (wb_adr_i == `LCDT_ADR_CTRL) begin
               wb_dat_o <= {27'h0, enable_r, psave_r, half_r, mode_r};
            end else if (wb_adr_i == `LCDT_ADR_STATUS) begin
               wb_dat_o <= {24'h0, buf_b_vld_r, buf_a_vld_r, oscillator_select_i,
                            pol_r, phase_r, bias_levels_o[1:0]};
            end else if (wb_adr_i >= `LCDT_ADR_PLANE0 && wb_adr_i <= `LCDT_ADR_PLANE3
                         && wb_adr_i[1:0] == 2'h0) begin
               wb_dat_o <= {8'h00, plane_mem[wb_adr_i[3:2]]};
            end
         end
      end
   end

   // control register; reset gives 1:4 with third bias, outputs parked
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         {enable_r, psave_r, half_r, mode_r} <= `LCDT_CTRL_RESET;
      end else if (wr_ctrl) begin
         mode_r   <= lcdt_mode_type'(wb_dat_i[`LCDT_CTRL_MODE_LSB +: 2]);
         half_r   <= wb_dat_i[`LCDT_CTRL_HALF_BIT];
         psave_r  <= wb_dat_i[`LCDT_CTRL_PSAVE_BIT];
         enable_r <= wb_dat_i[`LCDT_CTRL_EN_BIT];
      end
   end

   // display memory writes, byte lanes honoured
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < 4; i++) begin
            plane_mem[i] <= '0;
         end
      end else if (bus_req && wb_we_i && wb_adr_i >= `LCDT_ADR_PLANE0
                   && wb_adr_i <= `LCDT_ADR_PLANE3 && wb_adr_i[1:0] == 2'h0) begin
         for (int b = 0; b < 3; b++) begin
            if (wb_sel_i[b]) begin
               plane_mem[wb_adr_i[3:2]][8*b +: 8] <= wb_dat_i[8*b +: 8];
            end
         end
      end
   end

   // internal oscillator, derived from mclk; driven out for cascaded drivers
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         osc_cnt_r <= 16'h0000;
         osc_lvl_r <= 1'b0;
      end else if (oscillator_select_i) begin
         osc_cnt_r <= 16'h0000;
         osc_lvl_r <= 1'b0;
      end else if (osc_cnt_r == 16'(`LCDT_OSC_HALF_CYC - 1)) begin
         osc_cnt_r <= 16'h0000;
         osc_lvl_r <= ~osc_lvl_r;
      end else begin
         osc_cnt_r <= osc_cnt_r + 16'h0001;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         clk_pin_o    <= 1'b0;
         clk_pin_oe_o <= 1'b0;
         ext_prev_r   <= 1'b0;
      end else begin
         clk_pin_o    <= osc_lvl_r;
         clk_pin_oe_o <= ~oscillator_select_i;
         ext_prev_r   <= clk_pin_i;
      end
   end

   // one working-clock tick per rising edge of the selected source
   assign tick = oscillator_select_i ? (clk_pin_i & ~ext_prev_r)
                                     : (osc_cnt_r == 16'(`LCDT_OSC_HALF_CYC - 1) & ~osc_lvl_r);

   assign slot_end   = tick && (slot_cnt_r >= lcdt_slot_len(mode_r, psave_r) - 12'd1);
   assign next_phase = ({1'b0, phase_r} + 3'd1 >= planes) ? 2'h0 : phase_r + 2'h1;
   // another driver pulling sync low while we do not drive it
   assign sync_seen  = ~cascade_sync_i & ~cascade_sync_oe_o;

   // slot, phase and polarity sequencing
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         slot_cnt_r <= 12'h000;
         phase_r    <= 2'h0;
         pol_r      <= 1'b0;
      end else if (sync_seen || {1'b0, phase_r} >= planes) begin
         slot_cnt_r <= 12'h000;
         phase_r    <= 2'h0;
         pol_r      <= 1'b0;
      end else if (slot_end) begin
         slot_cnt_r <= 12'h000;
         phase_r    <= next_phase;
         if (next_phase == 2'h0) begin
            pol_r <= ~pol_r;
         end
      end else if (tick) begin
         slot_cnt_r <= slot_cnt_r + 12'h001;
      end
   end

   // sync pulled low for the first slot of each frame
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         cascade_sync_o    <= 1'b0;
         cascade_sync_oe_o <= 1'b0;
         frame_rate_o      <= 1'b0;
      end else begin
         cascade_sync_o    <= 1'b0;
         cascade_sync_oe_o <= (phase_r == 2'h0) & ~pol_r & (slot_cnt_r != 12'h000);
         frame_rate_o      <= ~pol_r;
      end
   end

   // shift register fills with the next plane during the slot, serially
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         shift_r     <= '0;
         shift_cnt_r <= 5'h00;
      end else if (slot_end || sync_seen) begin
         shift_cnt_r <= 5'h00;
      end else if (shift_cnt_r < 5'(`LCDT_NUM_SEG)) begin
         shift_r     <= {plane_mem[next_phase][shift_cnt_r], shift_r[`LCDT_NUM_SEG-1:1]};
         shift_cnt_r <= shift_cnt_r + 5'h01;
      end
   end

   // display register reloads only at a slot boundary
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         disp_r <= '0;
      end else if (slot_end) begin
         disp_r <= shift_r;
      end
   end

   // drive outputs; parked at the supply until enabled
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i || !enable_r) begin
         backplane_0_o     <= `LCDT_LVL_VDD;
         backplane_1_o     <= `LCDT_LVL_VDD;
         backplane_2_o     <= `LCDT_LVL_VDD;
         backplane_3_o     <= `LCDT_LVL_VDD;
         segment_outputs_o <= '0;
      end else begin
         backplane_0_o <= lcdt_bp_level(lcdt_bp_phase(mode_r, 2'h0) == phase_r, pol_r,
                                        half_r);
         backplane_1_o <= lcdt_bp_level(lcdt_bp_phase(mode_r, 2'h1) == phase_r, pol_r, half_r);
         backplane_2_o <= lcdt_bp_level(lcdt_bp_phase(mode_r, 2'h2) == phase_r, pol_r, half_r);
         backplane_3_o <= lcdt_bp_level(lcdt_bp_phase(mode_r, 2'h3) == phase_r, pol_r, half_r);
         for (int s = 0; s < `LCDT_NUM_SEG; s++) begin
            // on: opposite extreme to the active backplane; off: inner level or same extreme
            if (disp_r[s]) begin
               segment_outputs_o[2*s +: 2] <= pol_r ? `LCDT_LVL_VDD : `LCDT_LVL_VLCD;
            end else if (mode_r == LCDT_STATIC || half_r) begin
               segment_outputs_o[2*s +: 2] <= pol_r ? `LCDT_LVL_VLCD : `LCDT_LVL_VDD;
            end else begin
               segment_outputs_o[2*s +: 2] <= pol_r ? `LCDT_LVL_HIGH_MID : `LCDT_LVL_LOW_MID;
            end
         end
      end
   end

   // number of drive levels in use
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         bias_levels_o <= 3'd4;
      end else if (mode_r == LCDT_STATIC) begin
         bias_levels_o <= 3'd2;
      end else if (half_r) begin
         bias_levels_o <= 3'd3;
      end else begin
         bias_levels_o <= 3'd4;
      end
   end

   // byte path: a second byte waits in buffer b while scl is held low
   always_ff @(posedge mclk_i) begin
      if (!reset_n_i) begin
         buf_a_vld_r        <= 1'b0;
         buf_b_vld_r        <= 1'b0;
         buf_a_r            <= 8'h00;
         buf_b_r            <= 8'h00;
         byte_stored_o      <= 1'b0;
         byte_stored_data_o <= 8'h00;
         scl_o              <= 1'b0;
         scl_oe_o           <= 1'b0;
      end else begin
         byte_stored_o <= 1'b0;
         scl_o         <= 1'b0;
         if (buf_a_vld_r && tick) begin
            // storing takes one working clock, slow when the clock is slow
            byte_stored_o      <= 1'b1;
            byte_stored_data_o <= buf_a_r;
            buf_a_vld_r        <= buf_b_vld_r | byte_valid_i;
            buf_a_r            <= buf_b_vld_r ? buf_b_r : byte_data_i;
            buf_b_vld_r        <= buf_b_vld_r & byte_valid_i;
            buf_b_r            <= byte_data_i;
            scl_oe_o           <= buf_b_vld_r & byte_valid_i;
         end else if (byte_valid_i) begin
            if (!buf_a_vld_r) begin
               buf_a_vld_r <= 1'b1;
               buf_a_r     <= byte_data_i;
            end else if (!buf_b_vld_r) begin
               buf_b_vld_r <= 1'b1;
               buf_b_r     <= byte_data_i;
               scl_oe_o    <= 1'b1;
            end
         end else begin
            scl_oe_o <= buf_b_vld_r;
         end
      end
   end

endmodule // lcdt_drive
`default_nettype wire

// ---- tb/lcdt_drive_asserts.sv ----
// concurrent checks on the ports of the lcd drive timing block
`include "lcdt_params.svh"
`default_nettype none
module lcdt_drive_asserts (
   // clock and reset
   input wire logic                       mclk_i,
   input wire logic                       reset_n_i,
   // bus and pins watched
   input wire logic                       wb_cyc_i,
   input wire logic                       wb_stb_i,
   input wire logic                       wb_ack_o,
   input wire logic [31:0]                wb_dat_o,
   input wire logic                       oscillator_select_i,
   input wire logic                       clk_pin_oe_o,
   input wire logic                       cascade_sync_o,
   input wire logic                       scl_o,
   input wire logic                       scl_oe_o,
   input wire logic                       byte_stored_o,
   // drive outputs
   input wire logic [1:0]                 backplane_0_o,
   input wire logic [1:0]                 backplane_1_o,
   input wire logic [1:0]                 backplane_2_o,
   input wire logic [1:0]                 backplane_3_o,
   input wire logic [2*`LCDT_NUM_SEG-1:0] segment_outputs_o,
   input wire logic [2:0]                 bias_levels_o
);
   default clocking @(posedge mclk_i); endclocking
   default disable iff (!reset_n_i);
   sequence s_req;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence s_ans;
      wb_ack_o ##1 !wb_ack_o;
   endsequence
   chk_ack_timing: assert property (s_req |=> s_ans)
      else $error("bus answer not a single pulse one cycle after request");
   chk_rdata_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
      else $error("read data not zero outside ack");
   chk_osc_drive: assert property (!oscillator_select_i |=> clk_pin_oe_o)
      else $error("clock pin not driven with internal oscillator");
   chk_ext_input: assert property (oscillator_select_i |=> !clk_pin_oe_o)
      else $error("clock pin driven while external clock selected");
   chk_open_drain: assert property (!scl_o && !cascade_sync_o)
      else $error("open drain pin drives high");
   chk_stretch_end: assert property ($rose(scl_oe_o) |-> ##[1:600] byte_stored_o)
      else $error("serial clock held low without a byte being stored");
   chk_store_pulse: assert property (byte_stored_o |=> !byte_stored_o)
      else $error("byte stored pulse longer than one cycle");
   chk_bias_range: assert property (bias_levels_o inside {3'h2, 3'h3, 3'h4})
      else $error("bias level count out of range");
   chk_reset_state: assert property ($rose(reset_n_i) |-> (segment_outputs_o == '0
         && {backplane_0_o, backplane_1_o, backplane_2_o, backplane_3_o} == 8'h0
         && bias_levels_o == 3'h4))
      else $error("outputs not at supply level after reset");
endmodule // lcdt_drive_asserts

bind lcdt_drive lcdt_drive_asserts i_lcdt_drive_asserts (.mclk_i, .reset_n_i, .wb_cyc_i,
   .wb_stb_i, .wb_ack_o, .wb_dat_o, .oscillator_select_i, .clk_pin_oe_o, .cascade_sync_o,
   .scl_o, .scl_oe_o, .byte_stored_o, .backplane_0_o, .backplane_1_o, .backplane_2_o,
   .backplane_3_o, .segment_outputs_o, .bias_levels_o);
`default_nettype wire

// ---- tb/lcdt_panel_model.sv ----
// passive lcd cell model: net drive across one segment over each frame
`default_nettype none
module lcdt_panel_model (
   // clock and control
   input  wire logic       mclk_i,
   input  wire logic       watch_i,
   input  wire logic       half_i,
   input  wire logic       frame_rate_i,
   // one cell: backplane 0 against segment 0
   input  wire logic [1:0] bp_i,
   input  wire logic [1:0] seg_i,
   // frames judged and frames with net drive left over
   output int              frames_o,
   output int              bad_o
);
   timeunit 1ns;
   timeprecision 1ps;
   int   sum_r = 0;
   logic fr_q  = 1'b0;
   initial frames_o = 0;
   initial bad_o = 0;
   // level in sixths of the lcd voltage; under half bias code 1 is the single midpoint
   function automatic int lvl6(input logic [1:0] c);
      lvl6 = (half_i && c == 2'h1) ? 3 : 2 * int'(c);
   endfunction
   // liquid crystal degrades under any dc left over a whole frame
   always @(posedge mclk_i) begin
      fr_q <= frame_rate_i;
      if (frame_rate_i && !fr_q) begin
         if (watch_i) begin
            frames_o <= frames_o + 1;
            if (sum_r != 0) bad_o <= bad_o + 1;
         end
         sum_r <= lvl6(seg_i) - lvl6(bp_i);
      end else
         sum_r <= sum_r + lvl6(seg_i) - lvl6(bp_i);
   end
endmodule // lcdt_panel_model
`default_nettype wire

// ---- tb/lcdt_drive_test.sv ----
// self-checking bench for the lcd drive timing block
`include "lcdt_params.svh"
`default_nettype none
module lcdt_drive_test import lcdt_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk_i = 0, reset_n_i = 0, cyc = 0, stb = 0, we = 0, osel = 1;
   logic        ext_clk = 0, bv = 0, watch = 0, half = 0, ack, cpo, cpoe, syo, syoe;
   logic        stored, sclo, scloe, fr;
   logic [7:0]  adr = 0, bd = 0, sdat;
   logic [31:0] wdat = 0, rdat, q;
   logic [1:0]  bp0, bp1, bp2, bp3;
   logic [47:0] seg;
   logic [2:0]  bias;
   int          n_fail = 0, tests_run = 0, ext_cnt = 0, ph = 0, frames, bad;
   wire         clk_pin = cpoe ? cpo : ext_clk;
   wire         sync_w  = !syoe;
   always #10 mclk_i = ~mclk_i;
   // external working clock, a quarter of mclk, never stopped
   always @(posedge mclk_i) begin
      ph <= ph + 1;
      if (ph[0]) begin
         ext_clk <= ~ext_clk;
         if (!ext_clk) ext_cnt <= ext_cnt + 1;
      end
   end
   lcdt_drive i_lcdt_drive (.mclk_i(mclk_i), .reset_n_i(reset_n_i), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .oscillator_select_i(osel), .clk_pin_i(clk_pin),
      .clk_pin_o(cpo), .clk_pin_oe_o(cpoe), .cascade_sync_i(sync_w), .cascade_sync_o(syo),
      .cascade_sync_oe_o(syoe), .byte_valid_i(bv), .byte_data_i(bd), .byte_stored_o(stored),
      .byte_stored_data_o(sdat), .scl_o(sclo), .scl_oe_o(scloe), .backplane_0_o(bp0),
      .backplane_1_o(bp1), .backplane_2_o(bp2), .backplane_3_o(bp3),
      .segment_outputs_o(seg), .bias_levels_o(bias), .frame_rate_o(fr));
   lcdt_panel_model i_lcdt_panel_model (.mclk_i(mclk_i), .watch_i(watch), .half_i(half),
      .frame_rate_i(fr),
      .bp_i(bp0), .seg_i(seg[1:0]), .frames_o(frames), .bad_o(bad));
   task complete_run;
      if (n_fail == 0 && tests_run > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   task check(input logic [47:0] seen, input logic [47:0] exp);
      tests_run++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int i;
      @(posedge mclk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      for (i = 0; i < 50; i++) begin
         @(posedge mclk_i);
         if (ack === 1'b1) break;
      end
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      if (i == 50) begin
         n_fail++;
         complete_run();
      end
   endtask
   // frame boundary: rising edge of the frame square wave
   task wait_rise;
      int   i;
      logic p;
      p = fr;
      for (i = 0; i < 20000; i++) begin
         @(posedge mclk_i);
         if (fr === 1'b1 && p === 1'b0) break;
         p = fr;
      end
      if (i == 20000) begin
         n_fail++;
         complete_run();
      end
   endtask
   task t_reset;
      @(posedge mclk_i);
      check({37'h0, bp0, bp1, bp2, bp3, bias}, 48'h4);
      check(seg, 48'h0);
      wb(1'b0, `LCDT_ADR_CTRL, 32'h0);
      check(48'(q[4:0]), 48'(`LCDT_CTRL_RESET));
      wb(1'b1, 8'h08, 32'hffffffff);
      wb(1'b0, 8'h08, 32'h0);
      check(48'(q), 48'h0);
   endtask
   task t_rate(input logic [31:0] ctl, input int exp);
      int c;
      wb(1'b1, `LCDT_ADR_CTRL, ctl);
      wait_rise();
      wait_rise();
      c = ext_cnt;
      wait_rise();
      check(48'(ext_cnt - c), 48'(exp));
   endtask
   task t_modes;
      logic [4:0] ctl [5] = '{5'h18, 5'h19, 5'h1d, 5'h1e, 5'h1b};
      logic [2:0] exb [5] = '{3'h2, 3'h4, 3'h3, 3'h3, 3'h4};
      logic       e;
      logic [2:0] d4;
      wb(1'b1, `LCDT_ADR_PLANE0, 32'h000001);
      wb(1'b0, `LCDT_ADR_PLANE0, 32'h0);
      check(48'(q), 48'h1);
      for (int k = 0; k < 5; k++) begin
         watch <= 1'b0;
         half <= ctl[k][2];
         wb(1'b1, `LCDT_ADR_CTRL, 32'(ctl[k]));
         wait_rise();
         wait_rise();
         watch <= 1'b1;
         e = 0;
         d4 = 0;
         for (int i = 0; i < 2000; i++) begin
            @(posedge mclk_i);
            case (ctl[k][1:0])
               LCDT_STATIC: e |= bp1 !== bp0 || bp2 !== bp0 || bp3 !== bp0
                  || seg[1:0] === bp0 || seg[3:2] !== bp0;
               LCDT_MUX2: e |= bp2 !== bp0 || bp3 !== bp1;
               LCDT_MUX3: e |= bp3 !== bp1;
               default: begin
                  d4 |= {bp0 !== bp1, bp1 !== bp2, bp2 !== bp3};
                  e |= (seg[1:0] inside {2'h0, 2'h3}) != (bp0 inside {2'h0, 2'h3});
               end
            endcase
         end
         check(48'(e), 48'h0);
         check(48'(bias), 48'(exb[k]));
         if (ctl[k][1:0] == 2'h3) check(48'(d4), 48'h7);
      end
      watch <= 1'b0;
      check(48'(bad), 48'h0);
      check(48'(frames > 3), 48'h1);
   endtask
   task t_bytes;
      logic [7:0] got [2];
      int         n;
      logic       cp;
      int         tg;
      osel <= 1'b0;
      repeat (4) @(posedge mclk_i);
      check(48'(cpoe), 48'h1);
      bv <= 1'b1;
      bd <= 8'h5a;
      @(posedge mclk_i);
      bv <= 1'b0;
      @(posedge mclk_i);
      bv <= 1'b1;
      bd <= 8'ha5;
      @(posedge mclk_i);
      bv <= 1'b0;
      repeat (2) @(posedge mclk_i);
      check(48'(scloe), 48'h1);
      wb(1'b0, `LCDT_ADR_STATUS, 32'h0);
      check(48'(q[7:6]), 48'h3);
      n = 0;
      tg = 0;
      cp = cpo;
      for (int i = 0; i < 2000 && n < 2; i++) begin
         @(posedge mclk_i);
         tg += int'(cpo !== cp);
         cp = cpo;
         if (stored === 1'b1) begin
            got[n] = sdat;
            n++;
         end
      end
      check(48'({got[0], got[1], scloe}), 48'h0b54a);
      check(48'(tg != 0), 48'h1);
      osel <= 1'b1;
      repeat (3) @(posedge mclk_i);
      check(48'(cpoe), 48'h0);
   endtask
   initial begin
      repeat (20) @(posedge mclk_i);
      reset_n_i <= 1'b1;
      t_reset();
      t_rate(32'h1b, 480);
      t_modes();
      t_rate(32'h13, 2880);
      t_bytes();
      complete_run();
   end
endmodule // lcdt_drive_test
`default_nettype wire
